/* File: rtl/dfl_top.sv */
// run frequency shaping, stop mode selection and dc brake sequencing
`timescale 1ns/1ps
module dfl_top
  import dfl_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC,
  parameter int RAMP_DIV = RAMP_CYC,
  parameter logic [FREQ_W-1:0] RAMP_STEP = 16'h000a
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire dfl_src_t src_sel_i,
  input wire logic [FREQ_W-1:0] analog_freq_i,
  input wire logic [FREQ_W-1:0] keypad_freq_i,
  input wire logic [1:0] stop_method_sel_i,
  input wire logic [FREQ_W-1:0] freq_ceiling_i,
  input wire logic [FREQ_W-1:0] freq_floor_start_i,
  input wire logic clamp_enable_i,
  input wire logic [FREQ_W-1:0] clamp_high_i,
  input wire logic [FREQ_W-1:0] clamp_low_i,
  input wire logic skip_enable_i,
  input wire dfl_band_t [NUM_BANDS-1:0] skip_band_i,
  input wire logic [FREQ_W-1:0] brake_onset_freq_i,
  input wire logic [TIME_W-1:0] brake_wait_time_i,
  input wire logic [PCT_W-1:0] stop_brake_level_i,
  input wire logic [TIME_W-1:0] stop_brake_time_i,
  input wire logic [PCT_W-1:0] start_brake_level_i,
  input wire logic [TIME_W-1:0] start_brake_time_i,
  input wire logic [CUR_W-1:0] motor_rated_current_i,
  input wire logic [4:0] input3_function_sel_i,
  input wire logic multi_input_3_i,
  input wire logic start_dc_hold_i,
  output logic [FREQ_W-1:0] target_freq_o,
  output logic [FREQ_W-1:0] out_freq_o,
  output logic out_enable_o,
  output dfl_dc_t dc_o,
  output logic accel_o,
  output logic decel_o,
  output logic brake_busy_o
);
  typedef enum logic [2:0] {
    DFL_IDLE,
    DFL_SDC,
    DFL_RUN,
    DFL_STOPPING,
    DFL_WAIT,
    DFL_INJECT,
    DFL_DONE
  } dfl_state_t;

  dfl_state_t state_ff;
  logic tick;
  logic ramp_tick_ff;
  logic [31:0] ramp_cnt_ff;
  logic [TIME_W-1:0] tcnt_ff;
  logic [FREQ_W-1:0] raw_freq;
  logic [FREQ_W-1:0] lim_freq;
  logic [FREQ_W-1:0] clamp_freq;
  logic [FREQ_W-1:0] nxt_target;
  logic [FREQ_W-1:0] target_ff;
  logic [FREQ_W-1:0] prev_set_ff;
  logic dir_up_ff;
  logic set_rising;
  logic [FREQ_W-1:0] onset_v;
  logic [FREQ_W-1:0] out_ff;
  logic stop_brake_ok;
  logic start_brake_ok;
  logic dc_cmd;

  // clip a value into [lo, hi]; hi wins when the bounds cross
  function automatic logic [FREQ_W-1:0] fclip(input logic [FREQ_W-1:0] v,
                                               input logic [FREQ_W-1:0] lo,
                                               input logic [FREQ_W-1:0] hi);
    logic [FREQ_W-1:0] r;
    r = (v < lo) ? lo : v;
    fclip = (r > hi) ? hi : r;
  endfunction

  // rated current scaled by percent, full precision kept
  function automatic logic [DC_W-1:0] dc_scale(input logic [PCT_W-1:0] pct);
    logic [PCT_W-1:0] p;
    p = (pct > LEVEL_MAX) ? LEVEL_MAX : pct;
    dc_scale = DC_W'((motor_rated_current_i * p) / PCT_FULL);
  endfunction

  dfl_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // ramp step enable, the decel time is set by step and divider
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_cnt_ff <= '0;
      ramp_tick_ff <= 1'b0;
    end else if (ramp_cnt_ff >= 32'(RAMP_DIV - 1)) begin
      ramp_cnt_ff <= '0;
      ramp_tick_ff <= 1'b1;
    end else begin
      ramp_cnt_ff <= ramp_cnt_ff + 32'h1;
      ramp_tick_ff <= 1'b0;
    end
  end

  // setpoint shaping: limits, then clamp, then skip bands
  always_comb begin
    logic [FREQ_W-1:0] ceil_v;
    logic [FREQ_W-1:0] lo_e;
    logic [FREQ_W-1:0] hi_e;
    ceil_v = (freq_ceiling_i > FREQ_CEIL_MAX) ? FREQ_CEIL_MAX : freq_ceiling_i;
    lo_e = '0;
    hi_e = '0;
    raw_freq = (src_sel_i == DFL_SRC_KEYPAD) ? keypad_freq_i : analog_freq_i;
    lim_freq = (raw_freq > ceil_v) ? ceil_v : raw_freq;
    if (lim_freq < freq_floor_start_i) begin
      lim_freq = '0;
    end
    // both sources pass the same clamp
    clamp_freq = lim_freq;
    if (clamp_enable_i) begin
      clamp_freq = fclip(lim_freq, clamp_low_i, (clamp_high_i > ceil_v) ? ceil_v : clamp_high_i);
    end
    nxt_target = clamp_freq;
    // a setpoint parked inside a band keeps the direction it arrived from
    set_rising = (clamp_freq == prev_set_ff) ? dir_up_ff : (clamp_freq > prev_set_ff);
    if (skip_enable_i) begin
      for (int i = 0; i < NUM_BANDS; i++) begin
        lo_e = fclip(skip_band_i[i].low, freq_floor_start_i, ceil_v);
        hi_e = fclip(skip_band_i[i].high, freq_floor_start_i, ceil_v);
        if (clamp_freq > lo_e && clamp_freq < hi_e) begin
          // direction of the setpoint picks the edge held
          nxt_target = set_rising ? lo_e : hi_e;
        end
      end
    end
  end

  // remember last setpoint for direction, keep target steady
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_set_ff <= '0;
      dir_up_ff <= 1'b1;
      target_ff <= '0;
    end else begin
      // without this the held edge would flip once the setpoint stops moving
      if (clamp_freq != prev_set_ff) begin
        prev_set_ff <= clamp_freq;
        dir_up_ff <= (clamp_freq > prev_set_ff);
      end
      target_ff <= nxt_target;
    end
  end

  assign stop_brake_ok = (stop_brake_level_i != '0) && (stop_brake_time_i != '0);
  assign start_brake_ok = (start_brake_level_i != '0) && (start_brake_time_i != '0);
  assign dc_cmd = (input3_function_sel_i == FUNC_DC_AT_STOP) && multi_input_3_i;
  // brake onset setting is capped at its top of range
  assign onset_v = (brake_onset_freq_i > ONSET_MAX) ? ONSET_MAX : brake_onset_freq_i;

  // run and brake sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= DFL_IDLE;
      tcnt_ff <= '0;
    end else begin
      case (state_ff)
        DFL_IDLE: begin
          tcnt_ff <= '0;
          if (run_i) begin
            state_ff <= start_brake_ok ? DFL_SDC : DFL_RUN;
          end
        end
        DFL_SDC: begin
          if (!run_i) begin
            state_ff <= DFL_IDLE;
          end else if (tcnt_ff >= start_brake_time_i && !start_dc_hold_i) begin
            state_ff <= DFL_RUN;
            tcnt_ff <= '0;
          end else if (tick && tcnt_ff < start_brake_time_i) begin
            tcnt_ff <= tcnt_ff + 1'b1;
          end
        end
        DFL_RUN: begin
          if (!run_i) begin
            if (stop_method_sel_i == STOP_FREE) begin
              state_ff <= DFL_IDLE;
            end else begin
              state_ff <= DFL_STOPPING;
            end
          end
        end
        DFL_STOPPING: begin
          if (run_i) begin
            state_ff <= DFL_RUN;
          end else if (stop_method_sel_i == STOP_FREE) begin
            state_ff <= DFL_IDLE;
          end else if (stop_method_sel_i == STOP_DCBRAKE && stop_brake_ok && out_ff <= onset_v) begin
            state_ff <= DFL_WAIT;
            tcnt_ff <= '0;
          end else if (out_ff == '0) begin
            state_ff <= DFL_IDLE;
          end
        end
        DFL_WAIT: begin
          if (tcnt_ff >= brake_wait_time_i) begin
            state_ff <= DFL_INJECT;
            tcnt_ff <= '0;
          end else if (tick) begin
            tcnt_ff <= tcnt_ff + 1'b1;
          end
        end
        DFL_INJECT: begin
          if (tcnt_ff >= stop_brake_time_i) begin
            state_ff <= DFL_DONE;
          end else if (tick) begin
            tcnt_ff <= tcnt_ff + 1'b1;
          end
        end
        DFL_DONE: begin
          tcnt_ff <= '0;
          state_ff <= DFL_IDLE;
        end
        default: begin
          state_ff <= DFL_IDLE;
        end
      endcase
    end
  end

  // output frequency ramps, so skip bands are crossed freely
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_ff <= '0;
    end else begin
      case (state_ff)
        DFL_RUN: begin
          if (ramp_tick_ff) begin
            if (out_ff + RAMP_STEP <= target_ff) begin
              out_ff <= out_ff + RAMP_STEP;
            end else if (out_ff > target_ff + RAMP_STEP) begin
              out_ff <= out_ff - RAMP_STEP;
            end else begin
              out_ff <= target_ff;
            end
          end
        end
        DFL_STOPPING: begin
          if (ramp_tick_ff) begin
            out_ff <= (out_ff > RAMP_STEP) ? out_ff - RAMP_STEP : '0;
          end
        end
        default: begin
          // idle, start injection and brake phases give no frequency
          out_ff <= '0;
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_freq_o <= '0;
      out_freq_o <= '0;
      out_enable_o <= 1'b0;
      dc_o <= '0;
      accel_o <= 1'b0;
      decel_o <= 1'b0;
      brake_busy_o <= 1'b0;
    end else begin
      target_freq_o <= target_ff;
      out_freq_o <= out_ff;
      out_enable_o <= (state_ff == DFL_RUN) || (state_ff == DFL_STOPPING);
      accel_o <= (state_ff == DFL_RUN) && (out_ff < target_ff);
      decel_o <= (state_ff == DFL_STOPPING) || ((state_ff == DFL_RUN) && (out_ff > target_ff));
      brake_busy_o <= (state_ff == DFL_SDC) || (state_ff == DFL_WAIT) || (state_ff == DFL_INJECT);
      if (state_ff == DFL_INJECT) begin
        dc_o.on <= 1'b1;
        dc_o.level <= dc_scale(stop_brake_level_i);
      end else if (state_ff == DFL_SDC || (state_ff == DFL_IDLE && dc_cmd && !run_i)) begin
        dc_o.on <= 1'b1;
        dc_o.level <= dc_scale(start_brake_level_i);
      end else begin
        dc_o <= '0;
      end
    end
  end
endmodule // dfl_top

/* File: rtl/dfl_pkg.sv */
// constants and types for the drive frequency limit and dc brake block
package dfl_pkg;
  // frequencies in 0.01 hz units, times in 0.1 s units, levels in percent
  localparam int FREQ_W = 16;
  localparam int TIME_W = 10;
  localparam int PCT_W = 8;
  localparam int CUR_W = 12;
  localparam int DC_W = CUR_W + PCT_W;
  localparam logic [FREQ_W-1:0] FREQ_CEIL_MAX = 16'h9c40; // 400.00 hz
  localparam logic [FREQ_W-1:0] FREQ_CEIL_RST = 16'h1770; // 60.00 hz
  localparam logic [FREQ_W-1:0] FREQ_START_RST = 16'h0032; // 0.50 hz
  localparam logic [FREQ_W-1:0] CLAMP_HIGH_RST = 16'h1770;
  localparam logic [FREQ_W-1:0] CLAMP_LOW_RST = 16'h0032;
  localparam logic [FREQ_W-1:0] ONSET_MAX = 16'h1770; // 60.00 hz
  localparam logic [FREQ_W-1:0] ONSET_RST = 16'h01f4; // 5.00 hz
  localparam logic [TIME_W-1:0] WAIT_RST = 10'h001; // 0.1 s
  localparam logic [TIME_W-1:0] STOP_TIME_RST = 10'h00a; // 1.0 s
  localparam logic [PCT_W-1:0] LEVEL_RST = 8'h32; // 50 %
  localparam logic [PCT_W-1:0] LEVEL_MAX = 8'hc8; // 200 %
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64; // 100 %
  localparam logic [1:0] STOP_DECEL = 2'h0;
  localparam logic [1:0] STOP_DCBRAKE = 2'h1;
  localparam logic [1:0] STOP_FREE = 2'h2;
  localparam logic [4:0] FUNC_DC_AT_STOP = 5'h0b;
  localparam int NUM_BANDS = 3;
  // one time unit is 100 ms at 100 mhz
  localparam int CLK_HZ = 100000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int RAMP_MS = 10;
  localparam int RAMP_CYC = CLK_HZ / 1000 * RAMP_MS;

  typedef struct packed {
    logic [FREQ_W-1:0] low;
    logic [FREQ_W-1:0] high;
  } dfl_band_t;

  typedef struct packed {
    logic on;
    logic [DC_W-1:0] level;
  } dfl_dc_t;

  typedef enum logic [1:0] {
    DFL_SRC_ANALOG,
    DFL_SRC_KEYPAD,
    DFL_SRC_RSVD0,
    DFL_SRC_RSVD1
  } dfl_src_t;
endpackage

/* File: rtl/dfl_tick.sv */
// enable pulse divider for slow timing
`timescale 1ns/1ps
module dfl_tick
  import dfl_pkg::*;
#(
  parameter int DIV = TICK_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_ff;

  // free running count, one pulse per period
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else if (cnt_ff >= 32'(DIV - 1)) begin
      cnt_ff <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // dfl_tick

/* File: bench/dfl_operator_model.sv */
// operator side model: nameplate current and the dc-at-stop terminal
`timescale 1ns/1ps
module dfl_operator_model
  import dfl_pkg::*;
#(
  parameter logic [CUR_W-1:0] NAMEPLATE = 12'h0c8 // plain figure, arbitrary units
) (
  input wire logic hold_dc_req_i,
  output logic [CUR_W-1:0] motor_rated_current_o,
  output logic multi_input_3_o
);
  // every brake percentage scales this, so it never moves during a run
  assign motor_rated_current_o = NAMEPLATE;
  // terminal simply follows the operator's request
  assign multi_input_3_o = hold_dc_req_i;
endmodule // dfl_operator_model

/* File: bench/dfl_top_checker.sv */
// assertions on the ports of the frequency limit and dc brake block
`timescale 1ns/1ps
module dfl_top_checker
  import dfl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] stop_method_sel_i,
  input wire logic [FREQ_W-1:0] freq_ceiling_i,
  input wire logic [FREQ_W-1:0] freq_floor_start_i,
  input wire logic [PCT_W-1:0] stop_brake_level_i,
  input wire logic [TIME_W-1:0] stop_brake_time_i,
  input wire logic [PCT_W-1:0] start_brake_level_i,
  input wire logic [TIME_W-1:0] start_brake_time_i,
  input wire logic [CUR_W-1:0] motor_rated_current_i,
  input wire logic [4:0] input3_function_sel_i,
  input wire logic [FREQ_W-1:0] target_freq_o,
  input wire logic [FREQ_W-1:0] out_freq_o,
  input wire logic out_enable_o,
  input wire dfl_dc_t dc_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // scaled start level; only valid while levels stay within 200
  wire [DC_W-1:0] start_dc = {8'h00, motor_rated_current_i} * start_brake_level_i / PCT_FULL;
  a_ceiling_limit: assert property (target_freq_o != 16'h0000 |-> target_freq_o <= $past(freq_ceiling_i, 2))
    else $error("target above ceiling");
  a_start_floor: assert property (target_freq_o != 16'h0000 |-> target_freq_o >= $past(freq_floor_start_i, 2))
    else $error("target below start frequency");
  // output frequency register sits two stages behind the state, enable one
  a_free_coast: assert property ($fell(run_i) && stop_method_sel_i == STOP_FREE
    |-> ##3 (!out_enable_o && out_freq_o == 16'h0000))
    else $error("free run stop kept output");
  a_dc_not_driving: assert property (out_enable_o |-> !dc_o.on)
    else $error("dc injected while driving");
  a_start_level: assert property (dc_o.on && run_i && $past(run_i) |-> dc_o.level == start_dc)
    else $error("start dc level wrong");
  a_stop_skip: assert property (!run_i && !$past(run_i) && !$past(run_i, 2)
    && stop_method_sel_i == STOP_DCBRAKE && (stop_brake_level_i == 8'h00 || stop_brake_time_i == 10'h000)
    && input3_function_sel_i != FUNC_DC_AT_STOP |-> !dc_o.on)
    else $error("stop dc with zero setting");
  a_start_skip: assert property (run_i && $past(run_i) && $past(run_i, 2)
    && (start_brake_level_i == 8'h00 || start_brake_time_i == 10'h000) |-> !dc_o.on)
    else $error("start dc with zero setting");
  a_accel_after_dc: assert property ($rose(out_enable_o) && start_brake_level_i != 8'h00
    && start_brake_time_i != 10'h000 |-> $past(dc_o.on) || $past(dc_o.on, 2))
    else $error("accel without start dc");
  // main scenarios reached
  c_stop_dc: cover property (dc_o.on && !run_i);
  c_drive_on: cover property ($rose(out_enable_o));
  c_coast: cover property ($fell(run_i) && stop_method_sel_i == STOP_FREE);
endmodule // dfl_top_checker

bind dfl_top dfl_top_checker dfl_top_checker_inst (.core_clk_i, .rst_i, .run_i, .stop_method_sel_i,
  .freq_ceiling_i, .freq_floor_start_i, .stop_brake_level_i, .stop_brake_time_i, .start_brake_level_i,
  .start_brake_time_i, .motor_rated_current_i, .input3_function_sel_i, .target_freq_o, .out_freq_o,
  .out_enable_o, .dc_o);

/* File: bench/drive_freq_limit_dc_brake_test.sv */
// self-checking bench for the frequency limit and dc brake block
`timescale 1ns/1ps
module drive_freq_limit_dc_brake_test
  import dfl_pkg::*;
;
  localparam logic [15:0] CEIL = 16'h1770, FLOOR = 16'h0032, LO = 16'h03e8, HI = 16'h1388;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, cl = 1'b0, sk = 1'b0, hold = 1'b0, req = 1'b0;
  logic oen, acc, dec, busy, mi3, band_seen = 1'b0;
  dfl_src_t src = DFL_SRC_ANALOG;
  logic [1:0] mode = STOP_DCBRAKE;
  logic [15:0] an = 16'h0000, kp = 16'h0000, tgt, outf, sp;
  logic [9:0] wt = WAIT_RST, st = 10'h003, bt = 10'h002;
  logic [7:0] sl = 8'h64, bl = LEVEL_RST;
  logic [4:0] fsel = 5'h00;
  logic [11:0] rated;
  dfl_dc_t dc;
  dfl_band_t [NUM_BANDS-1:0] bands = {16'h1194, 16'h12c0, 16'h1194, 16'h12c0, 16'h07d0, 16'h0bb8};
  logic [15:0] corner [5] = '{16'h0031, 16'h0032, 16'h1770, 16'h1771, 16'hffff};
  logic [15:0] sk_in [5] = '{16'h0640, 16'h0960, 16'h0c80, 16'h0a00, 16'h0500};
  logic [15:0] sk_ex [5] = '{16'h0640, 16'h07d0, 16'h0c80, 16'h0bb8, 16'h0500};
  int n_fail = 0, tests_run = 0, seed = 18763, n, cyc = 0;

  dfl_top #(.TICK_DIV(10), .RAMP_DIV(2)) dfl_top_inst (.core_clk_i(clk), .rst_i(rst), .run_i(run),
    .src_sel_i(src), .analog_freq_i(an), .keypad_freq_i(kp), .stop_method_sel_i(mode), .freq_ceiling_i(CEIL),
    .freq_floor_start_i(FLOOR), .clamp_enable_i(cl), .clamp_high_i(HI), .clamp_low_i(LO), .skip_enable_i(sk),
    .skip_band_i(bands), .brake_onset_freq_i(ONSET_RST), .brake_wait_time_i(wt), .stop_brake_level_i(sl),
    .stop_brake_time_i(st), .start_brake_level_i(bl), .start_brake_time_i(bt), .motor_rated_current_i(rated),
    .input3_function_sel_i(fsel), .multi_input_3_i(mi3), .start_dc_hold_i(hold), .target_freq_o(tgt),
    .out_freq_o(outf), .out_enable_o(oen), .dc_o(dc), .accel_o(acc), .decel_o(dec), .brake_busy_o(busy));
  dfl_operator_model dfl_operator_model_inst (.hold_dc_req_i(req), .motor_rated_current_o(rated),
    .multi_input_3_o(mi3));

  // free-running clock, 10 ns period
  initial forever #5 clk = ~clk;
  // note any output frequency strictly inside the first skip band
  always @(posedge clk) if (oen && outf > 16'h07d0 && outf < 16'h0bb8) band_seen <= 1'b1;
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude;
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DC_W-1:0] got, input logic [DC_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // wait for oen (0), dc on (1) or out freq (2) to reach v, cycles in n; running out is a mismatch
  task automatic wait_on(input int sel, input logic [15:0] v, input int lim);
    logic [15:0] cur;
    n = 0;
    cur = (sel == 0) ? 16'(oen) : (sel == 1) ? 16'(dc.on) : outf;
    while (cur !== v && n < lim) begin
      @(negedge clk);
      n++;
      cur = (sel == 0) ? 16'(oen) : (sel == 1) ? 16'(dc.on) : outf;
    end
    if (cur !== v) begin
      n_fail++;
      $display("[ERR] %0t wait on %0d timed out", $time, sel);
    end
  endtask

  // limits first, then the optional clamp; skip is off in the random part
  function automatic logic [15:0] exp_f(input logic [15:0] f, input logic c);
    if (f > CEIL) f = CEIL;
    if (f < FLOOR) f = 16'h0000;
    if (c && f > HI) f = HI;
    if (c && f < LO) f = LO;
    return f;
  endfunction

  // main sequence, inputs changed on the falling edge
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 45; i++) begin
      sp = (i < 5) ? corner[i] : 16'($random(seed));
      cl = (i >= 5) && ($random(seed) & 1);
      if (cl) sp = sp | 16'h0040; // clamp below start frequency is left open
      src = dfl_src_t'(i % 4);
      an = (src == DFL_SRC_KEYPAD) ? ~sp : sp;
      kp = (src == DFL_SRC_KEYPAD) ? sp : ~sp;
      repeat (3) @(negedge clk);
      chk(tgt, exp_f(sp, cl), "limit");
    end
    cl = 1'b0;
    sk = 1'b1;
    src = DFL_SRC_KEYPAD;
    foreach (sk_in[i]) begin
      kp = sk_in[i];
      repeat (3) @(negedge clk);
      chk(tgt, sk_ex[i], "skip");
    end
    // start dc held past its time, ramp through band, then dc brake stop
    kp = 16'h0c80;
    wt = 10'h002;
    run = 1'b1;
    hold = 1'b1;
    repeat (60) @(negedge clk);
    chk({dc.on, oen, busy}, 3'b101, "start hold");
    hold = 1'b0;
    wait_on(0, 16'h1, 40);
    chk({oen, acc}, 2'b11, "accel after dc");
    wait_on(2, 16'h0c80, 2000);
    chk(band_seen, 1'b1, "ramp through band");
    run = 1'b0;
    wait_on(0, 16'h0, 2000);
    chk(busy, 1'b1, "brake wait busy");
    wait_on(1, 16'h1, 60);
    chk(20'(n >= 10 && n <= 24), 20'h1, "brake wait");
    chk(dc.level, 20'h000c8, "stop level");
    wait_on(1, 16'h0, 60);
    chk(20'(n >= 20 && n <= 34), 20'h1, "brake time");
    repeat (40) @(negedge clk);
    // zero settings: no start dc, decel stop and skipped dc stop both ramp
    bl = 8'h00;
    sl = 8'h00;
    kp = 16'h0320;
    for (int m = 0; m < 2; m++) begin
      mode = 2'(m);
      run = 1'b1;
      wait_on(0, 16'h1, 10);
      chk(20'(n <= 4), 20'h1, "no start dc");
      repeat (100) @(negedge clk);
      run = 1'b0;
      repeat (3) @(negedge clk);
      chk({oen, dec}, 2'b11, "ramping down");
      wait_on(2, 16'h0, 2000);
      chk(outf, 16'h0000, "ramped to zero");
      repeat (10) @(negedge clk);
    end
    mode = STOP_FREE;
    run = 1'b1;
    repeat (80) @(negedge clk);
    run = 1'b0;
    repeat (3) @(negedge clk);
    chk({outf, oen}, 17'h0, "coast");
    // terminal dc at stop, on its code and on another code
    bl = LEVEL_RST;
    for (int i = 0; i < 2; i++) begin
      fsel = (i == 0) ? FUNC_DC_AT_STOP : 5'h04;
      req = 1'b1;
      repeat (4) @(negedge clk);
      chk(20'(dc.on), 20'(i == 0), "stop dc input");
      if (i == 0) chk(dc.level, 20'h00064, "stop dc level");
      req = 1'b0;
      repeat (4) @(negedge clk);
      chk(20'(dc.on), 20'h0, "stop dc release");
    end
    conclude();
  end
endmodule // drive_freq_limit_dc_brake_test
